/* File: hw/cdt_axil_slave.v */
// AXI4-Lite slave front end: accepts address and data in either order, one access each way.
`default_nettype none
`include "cdt_defines.vh"
module cdt_axil_slave (
    input wire mclk,
    input wire rstn,
    input wire [`CDT_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`CDT_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output wire wr_go,
    output wire [9:0] wr_idx,
    output reg [15:0] wr_data,
    output reg [1:0] wr_strb,
    input wire wr_hit,
    output wire [9:0] rd_idx,
    output wire rd_go,
    input wire [15:0] rd_data,
    input wire rd_hit
);
    reg aw_full_r;
    reg w_full_r;
    reg [`CDT_ADDR_W-1:0] awaddr_r;

    // Channels stall while a response is still waiting, so one write is in flight at most.
    assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
    assign s_axi_wready = !w_full_r && !s_axi_bvalid;
    assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
    assign wr_idx = awaddr_r[`CDT_IDX_HI:`CDT_IDX_LO];
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign rd_idx = s_axi_araddr[`CDT_IDX_HI:`CDT_IDX_LO];

    // Write path: hold both halves, commit once both are in, then answer.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awaddr_r <= {`CDT_ADDR_W{1'b0}};
            wr_data <= 16'h0000;
            wr_strb <= 2'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CDT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                wr_data <= s_axi_wdata[15:0];
                wr_strb <= s_axi_wstrb[1:0];
            end
            if (wr_go) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `CDT_RESP_OKAY : `CDT_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read path: data is captured at the address handshake, upper half reads as zero.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CDT_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_hit ? rd_data : 16'h0000};
            s_axi_rresp <= rd_hit ? `CDT_RESP_OKAY : `CDT_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: hw/cdt_defines.vh */
// Named offsets, fields, reset values and codes of the cable diagnostic register bank.
`ifndef CDT_DEFINES_VH
`define CDT_DEFINES_VH

// Register indices; byte address is four times the index.
`define CDT_IDX_DONE_CTRL 10'h01e
`define CDT_IDX_LEN_DIAG 10'h155
`define CDT_IDX_MAIN_CTRL 10'h170
`define CDT_IDX_PULSE_CTRL 10'h171
`define CDT_IDX_LISTEN_CTRL 10'h173
`define CDT_IDX_THRESH_CTRL 10'h177
`define CDT_IDX_TX_LOC12 10'h180

// Bus address slicing.
`define CDT_ADDR_W 12
`define CDT_IDX_HI 11
`define CDT_IDX_LO 2

// Reset values.
`define CDT_RST_MAIN 16'h0e00
`define CDT_RST_PULSE 16'hc85c
`define CDT_RST_LISTEN 16'hffff
`define CDT_RST_THRESH 16'h1896
`define CDT_RST_ALCD_CTRL 3'h1

// Writable bit masks.
`define CDT_WMASK_MAIN 16'h6f00
`define CDT_WMASK_ALL 16'hffff

// Field positions.
`define CDT_MAIN_CROSS_DIS 14
`define CDT_MAIN_TX_BYP 13
`define CDT_MAIN_RX_BYP 12
`define CDT_MAIN_AVG_HI 10
`define CDT_MAIN_AVG_LO 8
`define CDT_DONE_START 0
`define CDT_DONE_FLAG 1
`define CDT_LEN_START 15
`define CDT_LEN_DONE 12

// Averaging code 111 is reserved and treated as the largest count.
`define CDT_AVG_RSVD 3'h7
`define CDT_AVG_MAX 3'h6

// AXI responses.
`define CDT_RESP_OKAY 2'h0
`define CDT_RESP_SLVERR 2'h2

`endif

/* File: hw/cdt_regs.v */
// Cable diagnostic register bank on AXI4-Lite, with the reflectometry sequencer attached.
`default_nettype none
`include "cdt_defines.vh"
//Function
// - Length diagnostic register bits 2:0 hold averaging control, read-write, reset 001.
// - Main control bit 14 set disables cross-pair mode; clear enables it.
// - Cross mode listens for reflections on the opposite pair to find shorts.
// - Bit 13 set skips the transmit pair run; clear measures it.
// - With transmit pair skipped, results land in the receive pair slots.
// - Bit 12 is a read-only receive pair bypass, reset 0.
// - Bits 10:8 select 2^code averaging runs; 111 reserved; reset 110.
// - Pulse control register bits 3:0 read-write, reset 1100.
// - Listen control register bits 15:8 read-write, reset all ones.
// - Threshold register bits 12:8 read-write, reset 11000.
// - Results are valid after done reads 1 and stay stable afterwards.
// - Location register gives transmit pair first peak 7:0, second 15:8.
// - Reserved read-only bits ignore writes and read as zero.
module cdt_regs (
    input wire mclk,
    input wire rstn,
    input wire [`CDT_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`CDT_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire tdr_run_req,
    output wire tdr_run_pair,
    output wire tdr_listen_pair,
    output wire tdr_cross_en,
    input wire tdr_run_done,
    input wire [7:0] tdr_peak_a,
    input wire [7:0] tdr_peak_b,
    output wire [3:0] tdr_pulse_ctrl,
    output wire [7:0] tdr_listen_len,
    output wire [4:0] tdr_short_thresh,
    output wire [15:0] rx_pair_peak_loc,
    output reg alcd_start,
    output wire [2:0] alcd_avg_ctrl,
    input wire alcd_finish,
    input wire [7:0] alcd_value
);
    wire wr_go;
    wire [9:0] wr_idx;
    wire [15:0] wr_data;
    wire [1:0] wr_strb;
    reg wr_hit;
    wire [9:0] rd_idx;
    wire rd_go;
    reg [15:0] rd_data;
    reg rd_hit;
    wire [15:0] strb_mask;

    reg [15:0] main_ctrl_r;
    reg [15:0] pulse_ctrl_r;
    reg [15:0] listen_ctrl_r;
    reg [15:0] thresh_ctrl_r;
    reg [2:0] alcd_ctrl_r;
    reg alcd_done_r;
    reg [7:0] alcd_out_r;
    reg diag_done_r;
    reg diag_start_r;

    wire eng_busy;
    wire eng_done_set;
    wire [15:0] tx_loc;
    wire [15:0] main_ctrl_nxt;

    cdt_axil_slave u_bus (
        .mclk(mclk),
        .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_go(wr_go),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_hit(wr_hit),
        .rd_idx(rd_idx),
        .rd_go(rd_go),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    cdt_tdr_engine u_eng (
        .mclk(mclk),
        .rstn(rstn),
        .start(diag_start_r),
        .tx_bypass(main_ctrl_r[`CDT_MAIN_TX_BYP]),
        .rx_bypass(main_ctrl_r[`CDT_MAIN_RX_BYP]),
        .cross_dis(main_ctrl_r[`CDT_MAIN_CROSS_DIS]),
        .avg_code(main_ctrl_r[`CDT_MAIN_AVG_HI:`CDT_MAIN_AVG_LO]),
        .run_req(tdr_run_req),
        .run_pair(tdr_run_pair),
        .listen_pair(tdr_listen_pair),
        .cross_en(tdr_cross_en),
        .run_done(tdr_run_done),
        .peak_a(tdr_peak_a),
        .peak_b(tdr_peak_b),
        .busy(eng_busy),
        .done_set(eng_done_set),
        .tx_loc(tx_loc),
        .rx_loc(rx_pair_peak_loc)
    );

    // Front-end settings are driven straight from the stored fields.
    assign tdr_pulse_ctrl = pulse_ctrl_r[3:0];
    assign tdr_listen_len = listen_ctrl_r[15:8];
    assign tdr_short_thresh = thresh_ctrl_r[12:8];
    assign alcd_avg_ctrl = alcd_ctrl_r;

    // Byte strobes cover the two low lanes; the upper lanes hold nothing.
    assign strb_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    // Only the documented writable bits can change, so read-only ones stay zero.
    assign main_ctrl_nxt = (main_ctrl_r & ~(strb_mask & `CDT_WMASK_MAIN))
                         | (wr_data & strb_mask & `CDT_WMASK_MAIN);

    // Address decode for writes; unmapped offsets answer with a slave error.
    always @* begin
        case (wr_idx)
            `CDT_IDX_DONE_CTRL: wr_hit = 1'b1;
            `CDT_IDX_LEN_DIAG: wr_hit = 1'b1;
            `CDT_IDX_MAIN_CTRL: wr_hit = 1'b1;
            `CDT_IDX_PULSE_CTRL: wr_hit = 1'b1;
            `CDT_IDX_LISTEN_CTRL: wr_hit = 1'b1;
            `CDT_IDX_THRESH_CTRL: wr_hit = 1'b1;
            `CDT_IDX_TX_LOC12: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Configuration registers. Reserved read-write bits are stored as written.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            main_ctrl_r <= `CDT_RST_MAIN;
            pulse_ctrl_r <= `CDT_RST_PULSE;
            listen_ctrl_r <= `CDT_RST_LISTEN;
            thresh_ctrl_r <= `CDT_RST_THRESH;
            alcd_ctrl_r <= `CDT_RST_ALCD_CTRL;
        end else if (wr_go) begin
            case (wr_idx)
                `CDT_IDX_MAIN_CTRL: main_ctrl_r <= main_ctrl_nxt;
                `CDT_IDX_PULSE_CTRL: begin
                    pulse_ctrl_r <= (pulse_ctrl_r & ~strb_mask) | (wr_data & strb_mask);
                end
                `CDT_IDX_LISTEN_CTRL: begin
                    listen_ctrl_r <= (listen_ctrl_r & ~strb_mask) | (wr_data & strb_mask);
                end
                `CDT_IDX_THRESH_CTRL: begin
                    thresh_ctrl_r <= (thresh_ctrl_r & ~strb_mask) | (wr_data & strb_mask);
                end
                `CDT_IDX_LEN_DIAG: begin
                    if (wr_strb[0]) begin
                        alcd_ctrl_r <= wr_data[2:0];
                    end
                end
                default: begin
                    alcd_ctrl_r <= alcd_ctrl_r;
                end
            endcase
        end
    end

    // Diagnostic start and done. A start while busy is dropped rather than restarting
    // mid-run, which would leave half-averaged values in the result slots.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            diag_start_r <= 1'b0;
            diag_done_r <= 1'b0;
        end else begin
            diag_start_r <= wr_go && (wr_idx == `CDT_IDX_DONE_CTRL) && wr_strb[0]
                            && wr_data[`CDT_DONE_START] && !eng_busy;
            if (eng_done_set) begin
                diag_done_r <= 1'b1;
            end else if (diag_start_r) begin
                diag_done_r <= 1'b0;
            end
        end
    end

    // Active length diagnostic: self-clearing start, done and result from the front end.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            alcd_start <= 1'b0;
            alcd_done_r <= 1'b0;
            alcd_out_r <= 8'h00;
        end else begin
            alcd_start <= wr_go && (wr_idx == `CDT_IDX_LEN_DIAG) && wr_strb[1]
                          && wr_data[`CDT_LEN_START];
            if (alcd_finish) begin
                alcd_done_r <= 1'b1;
                alcd_out_r <= alcd_value;
            end else if (alcd_start) begin
                alcd_done_r <= 1'b0;
            end
        end
    end

    // Read mux; reserved read-only bits return zero.
    always @* begin
        rd_hit = 1'b1;
        case (rd_idx)
            `CDT_IDX_DONE_CTRL: rd_data = {14'h0000, diag_done_r, 1'b0};
            `CDT_IDX_LEN_DIAG: begin
                rd_data = {3'h0, alcd_done_r, alcd_out_r, 1'b0, alcd_ctrl_r};
            end
            `CDT_IDX_MAIN_CTRL: rd_data = main_ctrl_r;
            `CDT_IDX_PULSE_CTRL: rd_data = pulse_ctrl_r;
            `CDT_IDX_LISTEN_CTRL: rd_data = listen_ctrl_r;
            `CDT_IDX_THRESH_CTRL: rd_data = thresh_ctrl_r;
            `CDT_IDX_TX_LOC12: rd_data = tx_loc;
            default: begin
                rd_data = 16'h0000;
                rd_hit = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

/* File: hw/cdt_tdr_engine.v */
// Reflectometry sequencer: runs each selected pair, averages peaks, publishes results.
`default_nettype none
`include "cdt_defines.vh"
module cdt_tdr_engine (
    input wire mclk,
    input wire rstn,
    input wire start,
    input wire tx_bypass,
    input wire rx_bypass,
    input wire cross_dis,
    input wire [2:0] avg_code,
    output reg run_req,
    output reg run_pair,
    output wire listen_pair,
    output reg cross_en,
    input wire run_done,
    input wire [7:0] peak_a,
    input wire [7:0] peak_b,
    output wire busy,
    output reg done_set,
    output reg [15:0] tx_loc,
    output reg [15:0] rx_loc
);
    localparam ST_IDLE = 2'h0;
    localparam ST_REQ = 2'h1;
    localparam ST_WAIT = 2'h2;
    localparam ST_NEXT = 2'h3;

    reg [1:0] state_r;
    reg [2:0] code_r;
    reg rx_byp_r;
    reg [6:0] runs_r;
    reg [13:0] acc_a_r;
    reg [13:0] acc_b_r;
    wire [2:0] code_eff;
    wire [6:0] runs_need;
    wire [13:0] avg_a;
    wire [13:0] avg_b;
    wire [15:0] avg_pair;

    // The reserved averaging code falls back to the largest legal count.
    assign code_eff = (avg_code == `CDT_AVG_RSVD) ? `CDT_AVG_MAX : avg_code;
    assign runs_need = 7'h01 << code_r;
    assign avg_a = acc_a_r >> code_r;
    assign avg_b = acc_b_r >> code_r;
    assign avg_pair = {avg_b[7:0], avg_a[7:0]};
    assign busy = (state_r != ST_IDLE);
    // Cross mode listens on the opposite pair to catch pair-to-pair shorts.
    assign listen_pair = cross_en ? ~run_pair : run_pair;

    // Sequencer. Config is latched at start so mid-run writes cannot skew a result.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            code_r <= 3'h0;
            rx_byp_r <= 1'b0;
            runs_r <= 7'h00;
            acc_a_r <= 14'h0000;
            acc_b_r <= 14'h0000;
            run_req <= 1'b0;
            run_pair <= 1'b0;
            cross_en <= 1'b0;
            done_set <= 1'b0;
            tx_loc <= 16'h0000;
            rx_loc <= 16'h0000;
        end else begin
            run_req <= 1'b0;
            done_set <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        code_r <= code_eff;
                        rx_byp_r <= rx_bypass;
                        cross_en <= !cross_dis;
                        runs_r <= 7'h00;
                        acc_a_r <= 14'h0000;
                        acc_b_r <= 14'h0000;
                        // Skipped transmit pair: its slot clears, receive data goes to receive slots.
                        run_pair <= tx_bypass;
                        if (tx_bypass) begin
                            tx_loc <= 16'h0000;
                        end
                        state_r <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    run_req <= 1'b1;
                    state_r <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (run_done) begin
                        acc_a_r <= acc_a_r + {6'h00, peak_a};
                        acc_b_r <= acc_b_r + {6'h00, peak_b};
                        runs_r <= runs_r + 7'h01;
                        state_r <= (runs_r + 7'h01 == runs_need) ? ST_NEXT : ST_REQ;
                    end
                end
                ST_NEXT: begin
                    runs_r <= 7'h00;
                    acc_a_r <= 14'h0000;
                    acc_b_r <= 14'h0000;
                    if (!run_pair) begin
                        tx_loc <= avg_pair;
                        if (rx_byp_r) begin
                            done_set <= 1'b1;
                            state_r <= ST_IDLE;
                        end else begin
                            run_pair <= 1'b1;
                            state_r <= ST_REQ;
                        end
                    end else begin
                        rx_loc <= avg_pair;
                        // Done only after the last pair's results are written.
                        done_set <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: verification/cdt_regs_checker.sv */
// Concurrent checks on the ports of the cable diagnostic register bank.
`default_nettype none
`include "cdt_defines.vh"
module cdt_regs_checker (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [`CDT_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`CDT_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tdr_run_req,
    input wire logic tdr_run_pair,
    input wire logic tdr_listen_pair,
    input wire logic tdr_cross_en,
    input wire logic tdr_run_done,
    input wire logic [7:0] tdr_peak_a,
    input wire logic [7:0] tdr_peak_b,
    input wire logic [3:0] tdr_pulse_ctrl,
    input wire logic [7:0] tdr_listen_len,
    input wire logic [4:0] tdr_short_thresh,
    input wire logic [15:0] rx_pair_peak_loc,
    input wire logic alcd_start,
    input wire logic [2:0] alcd_avg_ctrl,
    input wire logic alcd_finish,
    input wire logic [7:0] alcd_value
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // A response waiting on the master must neither vanish nor change.
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    sequence s_r_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    a_b_holds: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_holds: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answers: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered in time");
    a_rdata_upper_zero:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    // Configuration outputs may only move at the edge a write commits.
    a_pulse_on_write:
        assert property ($changed(tdr_pulse_ctrl) |-> $rose(s_axi_bvalid))
        else $error("pulse field moved without a write");
    a_listen_on_write:
        assert property ($changed(tdr_listen_len) |-> $rose(s_axi_bvalid))
        else $error("listen field moved without a write");
    a_thresh_on_write:
        assert property ($changed(tdr_short_thresh) |-> $rose(s_axi_bvalid))
        else $error("threshold moved without a write");
    a_avg_on_write:
        assert property ($changed(alcd_avg_ctrl) |-> $rose(s_axi_bvalid))
        else $error("average factor moved without a write");
    a_cross_listen:
        assert property (tdr_listen_pair == (tdr_run_pair ^ tdr_cross_en))
        else $error("listened pair does not follow cross mode");
    a_run_one_pulse:
        assert property (tdr_run_req |=> !tdr_run_req)
        else $error("run request longer than one cycle");
    // Receive results may only change shortly after a finished run.
    a_rx_loc_stable:
        assert property ($changed(rx_pair_peak_loc) |-> $past(tdr_run_done, 2)
            || $past(tdr_run_done, 3) || $past(tdr_run_done, 4))
        else $error("receive result changed without a run");
endmodule
bind cdt_regs cdt_regs_checker u_chk (.*);
`default_nettype wire

/* File: verification/test_cable_diag_tdr_regs.sv */
// Register and diagnostic sequence tests of the cable diagnostic bank.
`default_nettype none
`include "cdt_defines.vh"
module test_cable_diag_tdr_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rstn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, tdr_run_done = 0, alcd_finish = 0;
    logic [`CDT_ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 0, tdr_pulse_ctrl;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, par;
    logic tdr_run_req, tdr_run_pair, tdr_listen_pair, tdr_cross_en, alcd_start;
    logic [7:0] tdr_peak_a = 0, tdr_peak_b = 0, alcd_value = 0, tdr_listen_len;
    logic [4:0] tdr_short_thresh;
    logic [15:0] rx_pair_peak_loc;
    logic [2:0] alcd_avg_ctrl;
    logic pend = 0, first_pair, lp_xor;
    int failures = 0, compares = 0, runs = 0;
    cdt_regs DUT (.*);
    always #10 mclk = ~mclk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic close_out();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Both write channels are offered together and each dropped once taken.
    task automatic wr(input [9:0] idx, input [15:0] d, input [3:0] st, input [1:0] er);
        @(posedge mclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        // The answer is left waiting a cycle so the hold checks see a stalled response.
        s_axi_bready <= 1'b1;
        @(posedge mclk);
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, er);
    endtask
    task automatic rdr(input [9:0] idx);
        @(posedge mclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b1;
        @(posedge mclk);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask
    task automatic rchk(input string nm, input [9:0] idx, input [15:0] want);
        rdr(idx);
        chk(nm, rd, {16'h0000, want});
        chk("rresp", rsp, `CDT_RESP_OKAY);
    endtask
    // Front end stand-in: answers a run two edges later with peaks that alternate
    // by two, so a wrong run count or shift shows up as an offset in the average.
    always @(posedge mclk) begin
        tdr_run_done <= 1'b0;
        // Tallies restart when a diagnostic start is offered on the bus.
        if (s_axi_wvalid && s_axi_awaddr[11:2] == `CDT_IDX_DONE_CTRL) begin
            runs <= 0;
            par <= 2'b00;
        end else if (tdr_run_req) begin
            pend <= 1'b1;
            if (runs == 0) first_pair <= tdr_run_pair;
            runs <= runs + 1;
            lp_xor <= tdr_listen_pair ^ tdr_run_pair;
        end else if (pend) begin
            pend <= 1'b0;
            tdr_run_done <= 1'b1;
            tdr_peak_a <= (tdr_run_pair ? 8'h50 : 8'h10) + {par[tdr_run_pair], 1'b0};
            tdr_peak_b <= (tdr_run_pair ? 8'h60 : 8'h20) + {par[tdr_run_pair], 1'b0};
            par[tdr_run_pair] <= ~par[tdr_run_pair];
        end
    end
    task automatic diag(input [2:0] code, input logic xd, input logic byp);
        int nr;
        logic [7:0] a;
        nr = (code == 3'h7) ? 64 : (1 << code);
        a = (code == 3'h0) ? 8'h00 : 8'h01;
        wr(`CDT_IDX_MAIN_CTRL, {1'b1, xd, byp, 2'b11, code, 8'hff}, 4'h3, `CDT_RESP_OKAY);
        rchk("main", `CDT_IDX_MAIN_CTRL, {1'b0, xd, byp, 2'b01, code, 8'h00});
        wr(`CDT_IDX_DONE_CTRL, 16'h0001, 4'h1, `CDT_RESP_OKAY);
        while (runs == 0) @(posedge mclk);
        do rdr(`CDT_IDX_DONE_CTRL); while (rd[1] !== 1'b1);
        chk("runs", runs, nr * (byp ? 1 : 2));
        chk("first pair", first_pair, byp);
        chk("cross", lp_xor, !xd);
        rchk("tx loc", `CDT_IDX_TX_LOC12, byp ? 16'h0 : {8'h20 + a, 8'h10 + a});
        chk("rx loc", rx_pair_peak_loc, {8'h60 + a, 8'h50 + a});
    endtask
    // Reset values, field writes, lane strobes, reserved bits, then every average code.
    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        rchk("len", `CDT_IDX_LEN_DIAG, 16'h0001);
        rchk("main", `CDT_IDX_MAIN_CTRL, 16'h0e00);
        rchk("pulse", `CDT_IDX_PULSE_CTRL, 16'hc85c);
        rchk("listen", `CDT_IDX_LISTEN_CTRL, 16'hffff);
        rchk("thresh", `CDT_IDX_THRESH_CTRL, 16'h1896);
        rchk("tx loc", `CDT_IDX_TX_LOC12, 16'h0000);
        wr(`CDT_IDX_PULSE_CTRL, 16'h1233, 4'h3, `CDT_RESP_OKAY);
        chk("pulse out", tdr_pulse_ctrl, 4'h3);
        rdr(`CDT_IDX_PULSE_CTRL);
        chk("pulse field", rd[3:0], 4'h3);
        wr(`CDT_IDX_LISTEN_CTRL, 16'h7c11, 4'h3, `CDT_RESP_OKAY);
        wr(`CDT_IDX_LISTEN_CTRL, 16'h0000, 4'h1, `CDT_RESP_OKAY);
        rchk("listen", `CDT_IDX_LISTEN_CTRL, 16'h7c00);
        chk("listen out", tdr_listen_len, 8'h7c);
        wr(`CDT_IDX_THRESH_CTRL, 16'h0d00, 4'h3, `CDT_RESP_OKAY);
        chk("thresh out", tdr_short_thresh, 5'h0d);
        wr(`CDT_IDX_LEN_DIAG, 16'h6ffd, 4'h3, `CDT_RESP_OKAY);
        rchk("len", `CDT_IDX_LEN_DIAG, 16'h0005);
        chk("avg out", alcd_avg_ctrl, 3'h5);
        wr(10'h010, 16'h1234, 4'h3, `CDT_RESP_SLVERR);
        rdr(10'h010);
        chk("unmapped resp", rsp, `CDT_RESP_SLVERR);
        chk("unmapped data", rd, 32'h0);
        wr(`CDT_IDX_LEN_DIAG, 16'h8005, 4'h3, `CDT_RESP_OKAY);
        alcd_value <= 8'ha7;
        alcd_finish <= 1'b1;
        @(posedge mclk);
        alcd_finish <= 1'b0;
        rchk("len", `CDT_IDX_LEN_DIAG, 16'h1a75);
        for (int c = 0; c < 8; c++) diag(c[2:0], c[0], c == 2 || c == 5);
        close_out();
    end
    // Whole run needs well under 10000 cycles; this bound only cuts a hang.
    initial begin
        #400us;
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
